// >>> verilog/mcp_pkg.sv
// constants and types for the microphone clock-rate power sequencer
package mcp_pkg;

  // ----------------------------------------
  // clock and documented rates
  // ----------------------------------------
  localparam longint CLK_HZ = 40_000_000;
  localparam longint FS_LPL_HI_MHZ = 18_750_000;   // millihertz
  localparam longint FS_LPL_LO_MHZ = 6_250_000;    // millihertz
  localparam longint FS_SLEEP_MHZ = 3_125_000;     // millihertz
  localparam longint SCK_SBY_HZ = 200_000;
  localparam longint SLEEP_LIMIT_US = 1_000;

  // ----------------------------------------
  // derived counts in mclk cycles; WAKE_SCK in sck cycles
  // ----------------------------------------
  localparam int LPL_MIN_CYC = int'((CLK_HZ * 1000 + FS_LPL_HI_MHZ - 1) / FS_LPL_HI_MHZ);
  localparam int LPL_MAX_CYC = int'((CLK_HZ * 1000) / FS_LPL_LO_MHZ);
  localparam int SLEEP_CYC = int'((CLK_HZ * 1000) / FS_SLEEP_MHZ);
  localparam int SLEEP_LIMIT_CYC = int'((CLK_HZ * SLEEP_LIMIT_US) / 1_000_000);
  localparam int SBY_CYC = int'(CLK_HZ / SCK_SBY_HZ);
  localparam int HYST_CYC = 64;
  localparam int WAKE_SCK = 32768;

  // ----------------------------------------
  // widths and resets
  // ----------------------------------------
  localparam int SAMPLE_W = 24;
  localparam int WS_CNT_W = 17;
  localparam int SCK_CNT_W = 8;
  localparam int WAKE_CNT_W = 17;
  localparam int BIT_CNT_W = 5;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 24'h00_0000;

  typedef enum logic [2:0] {
    ST_SLEEP = 3'h1,
    ST_WAKE = 3'h2,
    ST_RUN = 3'h4
  } mcp_state_t;

endpackage : mcp_pkg

// >>> verilog/mcp_edge_if.sv
// edge events and levels from the pin synchroniser
`timescale 1ns/1ps
interface mcp_edge_if;
  logic sck_rise;
  logic sck_fall;
  logic ws_rise;
  logic ws_fall;
  logic chan_side_select;

  modport src (output sck_rise, output sck_fall, output ws_rise, output ws_fall, output chan_side_select);
  modport dst (input sck_rise, input sck_fall, input ws_rise, input ws_fall, input chan_side_select);
endinterface : mcp_edge_if

// >>> verilog/mcp_pin_sync.sv
// two-stage pin synchroniser with edge detection for sck and ws
`timescale 1ns/1ps
module mcp_pin_sync (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_sck,
  input wire logic i_ws,
  input wire logic i_channel_side_select,
  mcp_edge_if.src o_edge
);
  import mcp_pkg::*;

  // ----------------------------------------
  // synchroniser stages
  // ----------------------------------------
  logic [2:0] meta_r, meta_nxt;
  logic [2:0] sync_r, sync_nxt;
  logic [1:0] prev_r, prev_nxt;

  always_comb begin
    meta_nxt = {i_channel_side_select, i_ws, i_sck};
    sync_nxt = meta_r;
    prev_nxt = sync_r[1:0];
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
      prev_r <= 2'h0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  // ----------------------------------------
  // edge events
  // ----------------------------------------
  assign o_edge.sck_rise = sync_r[0] & ~prev_r[0];
  assign o_edge.sck_fall = ~sync_r[0] & prev_r[0];
  assign o_edge.ws_rise = sync_r[1] & ~prev_r[1];
  assign o_edge.ws_fall = ~sync_r[1] & prev_r[1];
  assign o_edge.chan_side_select = sync_r[2];

endmodule : mcp_pin_sync

// >>> verilog/mcp_power_seq.sv
// clock-rate driven power modes and serial data output of the microphone
//
// Summary of operation
// - frame rate 6.25 to 18.75 kHz selects low-power listening mode
// - frame rate below 3.125 kHz puts the device to sleep
// - in sleep the serial data line is released, never driven
// - sleep is reached within 1 ms of the rate falling below threshold
// - after sleep, count 32768 sck cycles before driving data again
// - a sleeping device neither drives nor loads a shared data line
// - channel select low uses left half after ws fall; high right after rise
// - release data line right after the lsb of the 24-bit word
// - sck below about 200 kHz means standby; exit like startup
`timescale 1ns/1ps
module mcp_power_seq #(
  parameter int P_LPL_MAX_CYC = mcp_pkg::LPL_MAX_CYC,
  parameter int P_SLEEP_CYC = mcp_pkg::SLEEP_CYC,
  parameter int P_WAKE_SCK = mcp_pkg::WAKE_SCK
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_sck,
  input wire logic i_ws,
  input wire logic i_channel_side_select,
  input wire logic [mcp_pkg::SAMPLE_W-1:0] i_sample,
  output logic o_sample_take,
  output logic o_sd,
  output logic o_sd_oe_n,
  output logic o_low_power_listening_mode,
  output logic o_sleep,
  output logic o_waking
);
  import mcp_pkg::*;

  mcp_edge_if edge_if ();

  mcp_pin_sync u_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_sck(i_sck),
    .i_ws(i_ws),
    .i_channel_side_select(i_channel_side_select),
    .o_edge(edge_if.src)
  );

  // ----------------------------------------
  // rate measurement
  // ----------------------------------------
  logic [WS_CNT_W-1:0] ws_cnt_r, ws_cnt_nxt;
  logic [SCK_CNT_W-1:0] sck_cnt_r, sck_cnt_nxt;
  logic lpl_r, lpl_nxt;
  mcp_state_t state_r, state_nxt;
  logic [WAKE_CNT_W-1:0] wake_cnt_r, wake_cnt_nxt;
  logic ws_idle;
  logic sck_idle;

  assign ws_idle = (ws_cnt_r > WS_CNT_W'(P_SLEEP_CYC));
  assign sck_idle = (sck_cnt_r > SCK_CNT_W'(SBY_CYC));

  always_comb begin
    ws_cnt_nxt = ws_cnt_r;
    sck_cnt_nxt = sck_cnt_r;
    lpl_nxt = lpl_r;
    if (state_r == ST_SLEEP) begin
      ws_cnt_nxt = '0;
    end else if (edge_if.ws_rise) begin
      ws_cnt_nxt = '0;
      if (ws_cnt_r >= WS_CNT_W'(LPL_MIN_CYC) && ws_cnt_r <= WS_CNT_W'(P_LPL_MAX_CYC)) begin
        lpl_nxt = 1'b1;
      end else if (ws_cnt_r < WS_CNT_W'(LPL_MIN_CYC - HYST_CYC)) begin
        lpl_nxt = 1'b0;
      end
    end else if (!ws_idle) begin
      ws_cnt_nxt = ws_cnt_r + WS_CNT_W'(1);
    end
    if (edge_if.sck_rise) begin
      sck_cnt_nxt = '0;
    end else if (!sck_idle) begin
      sck_cnt_nxt = sck_cnt_r + SCK_CNT_W'(1);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ws_cnt_r <= '0;
      sck_cnt_r <= '0;
      lpl_r <= 1'b0;
    end else begin
      ws_cnt_r <= ws_cnt_nxt;
      sck_cnt_r <= sck_cnt_nxt;
      lpl_r <= lpl_nxt;
    end
  end

  // ----------------------------------------
  // power state machine
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    wake_cnt_nxt = wake_cnt_r;
    unique case (state_r)
      ST_SLEEP: begin
        if (edge_if.sck_rise) begin
          state_nxt = ST_WAKE;
          wake_cnt_nxt = WAKE_CNT_W'(1);
        end
      end
      ST_WAKE: begin
        if (ws_idle || sck_idle) begin
          state_nxt = ST_SLEEP;
        end else if (wake_cnt_r >= WAKE_CNT_W'(P_WAKE_SCK)) begin
          state_nxt = ST_RUN;
        end else if (edge_if.sck_rise) begin
          wake_cnt_nxt = wake_cnt_r + WAKE_CNT_W'(1);
        end
      end
      ST_RUN: begin
        if (ws_idle || sck_idle) begin
          state_nxt = ST_SLEEP;
        end
      end
      default: begin
        state_nxt = ST_SLEEP;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_r <= ST_SLEEP;
      wake_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      wake_cnt_r <= wake_cnt_nxt;
    end
  end

  // ----------------------------------------
  // serial data output
  // ----------------------------------------
  logic [SAMPLE_W-1:0] sh_r, sh_nxt;
  logic [BIT_CNT_W-1:0] bit_r, bit_nxt;
  logic arm_r, arm_nxt;
  logic drv_r, drv_nxt;
  logic sd_r, sd_nxt;
  logic take_r, take_nxt;
  logic chan_edge;
  logic leave_run;

  // release on the same edge that leaves run, so sleep never sees a driven line
  assign leave_run = (state_nxt != ST_RUN);

  assign chan_edge = edge_if.chan_side_select ? edge_if.ws_rise : edge_if.ws_fall;

  always_comb begin
    sh_nxt = sh_r;
    bit_nxt = bit_r;
    arm_nxt = arm_r;
    drv_nxt = drv_r;
    sd_nxt = sd_r;
    take_nxt = 1'b0;
    if (leave_run) begin
      arm_nxt = 1'b0;
      drv_nxt = 1'b0;
      sd_nxt = 1'b0;
    end else if (chan_edge) begin
      arm_nxt = 1'b1;
      drv_nxt = 1'b0;
      sd_nxt = 1'b0;
      sh_nxt = i_sample;
      take_nxt = 1'b1;
    end else if (edge_if.sck_fall) begin
      if (arm_r) begin
        arm_nxt = 1'b0;
        drv_nxt = 1'b1;
        sd_nxt = sh_r[SAMPLE_W-1];
        sh_nxt = {sh_r[SAMPLE_W-2:0], 1'b0};
        bit_nxt = BIT_CNT_W'(SAMPLE_W - 1);
      end else if (drv_r) begin
        if (bit_r == '0) begin
          drv_nxt = 1'b0;
          sd_nxt = 1'b0;
        end else begin
          sd_nxt = sh_r[SAMPLE_W-1];
          sh_nxt = {sh_r[SAMPLE_W-2:0], 1'b0};
          bit_nxt = bit_r - BIT_CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sh_r <= SAMPLE_RST;
      bit_r <= '0;
      arm_r <= 1'b0;
      drv_r <= 1'b0;
      sd_r <= 1'b0;
      take_r <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      bit_r <= bit_nxt;
      arm_r <= arm_nxt;
      drv_r <= drv_nxt;
      sd_r <= sd_nxt;
      take_r <= take_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_sd = sd_r;
  assign o_sd_oe_n = ~drv_r;
  assign o_sample_take = take_r;
  assign o_low_power_listening_mode = lpl_r;
  assign o_sleep = state_r[0];
  assign o_waking = state_r[1];

endmodule : mcp_power_seq

// >>> tb/mcp_power_seq_props.sv
// port checks for the power sequencer
`timescale 1ns/1ps
module mcp_power_seq_props #(
  parameter int P_WAKE_SCK = 32768
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_sck,
  input wire logic i_ws,
  input wire logic o_sample_take,
  input wire logic o_sd,
  input wire logic o_sd_oe_n,
  input wire logic o_low_power_listening_mode,
  input wire logic o_sleep,
  input wire logic o_waking
);
  logic sck_q;
  int idle_cnt;
  int fall_cnt;
  int rise_cnt;
  always_ff @(posedge i_mclk) begin
    sck_q <= i_sck;
    idle_cnt <= (sck_q != i_sck) ? 0 : idle_cnt + int'(idle_cnt < 999);
    fall_cnt <= o_sd_oe_n ? 0 : fall_cnt + int'(sck_q & ~i_sck);
    rise_cnt <= o_waking ? rise_cnt + int'(~sck_q & i_sck) : 0;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_take;
    o_sample_take;
  endsequence
  sequence s_drive;
    // a word cut by a stopped clock is never driven
    ##[1:60] (!o_sd_oe_n || idle_cnt > 30);
  endsequence
  a_sleep_line_free: assert property (o_sleep |-> o_sd_oe_n && !o_sd && !o_sample_take)
    else $error("sd driven in sleep");
  a_idle_sleeps: assert property (idle_cnt >= 260 |-> o_sleep) else $error("no sleep");
  a_wake_quiet: assert property (o_waking |-> o_sd_oe_n) else $error("sd driven in wake");
  a_wake_first: assert property ($fell(o_sleep) |-> o_waking) else $error("no wake");
  a_wake_count: assert property ($fell(o_waking) && !o_sleep |-> rise_cnt == P_WAKE_SCK - 1)
    else $error("wake count wrong");
  a_take_drives: assert property (s_take |-> s_drive) else $error("word not driven");
  a_word_length: assert property ($rose(o_sd_oe_n) |-> fall_cnt == 24) else $error("bad length");
  a_mode_on_ws: assert property ($changed(o_low_power_listening_mode) && !o_sleep && !$past(o_sleep)
    |-> i_ws && $past(i_ws, 2)) else $error("mode change off ws");
endmodule : mcp_power_seq_props

// >>> tb/mcp_i2s_master.sv
// i2s master model, clocks stand low between frames
`timescale 1ns/1ps
module mcp_i2s_master (
  input wire logic i_run,
  input wire logic [15:0] i_half_ns,
  output logic o_sck,
  output logic o_ws
);
  initial begin
    o_sck = 1'b0;
    o_ws = 1'b0;
    #7;
    forever begin
      wait (i_run === 1'b1);
      for (int i = 0; i < 64; i++) begin
        #(i_half_ns) o_sck = 1'b1;
        #(i_half_ns) o_sck = 1'b0;
        if (i == 31 || i == 63) o_ws = ~o_ws;
      end
    end
  end
endmodule : mcp_i2s_master

// >>> tb/tb_mcp_power_seq.sv
// bench for the power sequencer
`timescale 1ns/1ps
module tb_mcp_power_seq;
  import mcp_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic sel = 1'b0;
  logic run = 1'b0;
  logic [15:0] half = 16'h0064;
  logic [SAMPLE_W-1:0] smp;
  logic sck, ws, take, sd, oe_n, lpl, slp, wak;
  wire sd_line = oe_n ? 1'b0 : sd;
  logic [SAMPLE_W-1:0] exp_q[$];
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  always #12.5 i_mclk = ~i_mclk;
  mcp_i2s_master u_master (.i_run(run), .i_half_ns(half), .o_sck(sck), .o_ws(ws));
  mcp_power_seq #(.P_WAKE_SCK(8)) dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sck(sck), .i_ws(ws),
    .i_channel_side_select(sel), .i_sample(smp), .o_sample_take(take), .o_sd(sd), .o_sd_oe_n(oe_n),
    .o_low_power_listening_mode(lpl), .o_sleep(slp), .o_waking(wak));
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d bad %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  always @(negedge i_mclk) begin
    cyc++;
    if (cyc > 60000) begin
      err_count++;
      wrap_up();
    end
  end
  always begin : mon
    logic [SAMPLE_W-1:0] w;
    @(negedge oe_n);
    chk(ws, sel);
    repeat (SAMPLE_W) @(negedge sck) w = {w[SAMPLE_W-2:0], sd_line};
    repeat (6) @(posedge i_mclk);
    chk({oe_n, sd_line}, 2'b10);
    chk(w, exp_q.pop_front());
  end
  initial begin : main
    int n;
    void'($urandom(11537));
    smp = $urandom;
    exp_q.push_back(smp);
    fork
      forever begin
        @(negedge i_mclk);
        if (take === 1'b1) begin
          smp = $urandom;
          exp_q.push_back(smp);
        end
      end
    join_none
    repeat (12) @(negedge i_mclk);
    i_rst_n = 1'b1;
    @(negedge i_mclk);
    chk({slp, wak, oe_n}, 3'b101);
    for (int s = 0; s < 2; s++) begin
      sel = s[0];
      half = 16'h0064;
      run = 1'b1;
      repeat (2000) @(negedge i_mclk);
      chk({slp, wak, lpl}, 3'b000);
      half = 16'h0271;
      repeat (9700) @(negedge i_mclk);
      chk(lpl, 1'b1);
      run = 1'b0;
      for (n = 0; n < 45000 && slp !== 1'b1; n++) @(negedge i_mclk);
      chk(n < SLEEP_LIMIT_CYC + 3200, 1'b1);
      chk({oe_n, sd_line}, 2'b10);
      // a left word armed by the last frame edge is cut by the stop
      chk(exp_q.size(), 32'(2 - s));
      exp_q.delete();
      exp_q.push_back(smp);
      $display("pass %0d done", s);
    end
    wrap_up();
  end
endmodule : tb_mcp_power_seq
bind mcp_power_seq mcp_power_seq_props #(.P_WAKE_SCK(P_WAKE_SCK)) u_props (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_sck(i_sck), .i_ws(i_ws), .o_sample_take(o_sample_take), .o_sd(o_sd), .o_sd_oe_n(o_sd_oe_n),
  .o_low_power_listening_mode(o_low_power_listening_mode), .o_sleep(o_sleep), .o_waking(o_waking));
